// ==== inc/fpw_pkg.sv ====
// Purpose: constants, types and helpers for the fan duty configuration block
// Assumes: 10 MHz CLK; duty carried as 8 bits, 1/256 of full scale per LSB
// Notes:   coarse duty keeps only the upper nibble (16/256 = 6.25 %)
package fpw_pkg;
   ////////////////////////////////////////////////////////////////////////////
   // register offsets
   localparam logic [7:0] ADDR_ENH_CFG  = 8'h45;
   localparam logic [7:0] ADDR_FAN_CFG  = 8'h4A;
   localparam logic [7:0] ADDR_PWM_VAL  = 8'h4C;
   ////////////////////////////////////////////////////////////////////////////
   // field positions
   localparam int ENH_FINE      = 4;
   localparam int ENH_USF       = 3;
   localparam int ENH_RATE_HI   = 2;
   localparam int ENH_RATE_LO   = 1;
   localparam int ENH_SMOOTH    = 0;
   localparam int FAN_PROG      = 5;
   ////////////////////////////////////////////////////////////////////////////
   // reset values and masks
   localparam logic [7:0] ENH_RST       = 8'h00;
   localparam logic [7:0] FAN_RST       = 8'h20;
   localparam logic [7:0] PWM_RST       = 8'h00;
   localparam logic [7:0] ENH_FREE_MASK = 8'h78;
   localparam logic [7:0] ENH_PROT_MASK = 8'h07;
   localparam logic [7:0] FAN_RD_MASK   = 8'h3F;
   ////////////////////////////////////////////////////////////////////////////
   // duty encoding
   localparam logic [7:0] DUTY_FULL     = 8'hFF;
   localparam logic [7:0] STEP_FINE     = 8'h01;
   localparam logic [7:0] STEP_COARSE   = 8'h10;
   localparam logic [7:0] COARSE_MASK   = 8'hF0;
   ////////////////////////////////////////////////////////////////////////////
   // ramp step intervals
   localparam int CLK_HZ        = 10_000_000;
   localparam int RAMP_T0_US    = 23_000;
   localparam int RAMP_T1_US    = 46_000;
   localparam int RAMP_T2_US    = 91_000;
   localparam int RAMP_T3_US    = 182_000;
   localparam int RAMP_T0_CYC   = RAMP_T0_US * (CLK_HZ / 1_000_000);
   localparam int RAMP_T1_CYC   = RAMP_T1_US * (CLK_HZ / 1_000_000);
   localparam int RAMP_T2_CYC   = RAMP_T2_US * (CLK_HZ / 1_000_000);
   localparam int RAMP_T3_CYC   = RAMP_T3_US * (CLK_HZ / 1_000_000);
   localparam int STEP_CNT_W    = 21;
   ////////////////////////////////////////////////////////////////////////////
   // duty source, one-hot
   typedef enum logic [3:0] {
      SRC_LUT  = 4'b0001,
      SRC_SOFT = 4'b0010,
      SRC_SPIN = 4'b0100,
      SRC_CRIT = 4'b1000
   } fpw_src_e;

   function automatic logic [7:0] fpw_quant(input logic [7:0] d, input logic fine);
      fpw_quant = fine ? d : (d & COARSE_MASK);
   endfunction : fpw_quant
endpackage : fpw_pkg

// ==== inc/fpw_step_if.sv ====
// Purpose: carries ramp step timing between the control and the step timer
// Assumes: both ends on CLK
// Notes:   tick is a one-cycle pulse
interface fpw_step_if;
   logic       run;
   logic [1:0] code;
   logic       tick;
   modport timer (input run, input code, output tick);
   modport ctrl  (output run, output code, input tick);
endinterface : fpw_step_if

// ==== src/fpw_step_timer.sv ====
// Purpose: paces ramp steps at the interval chosen by the interval code
// Assumes: run held high while a ramp is in progress
// Notes:   counter restarts whenever run drops, so a new ramp waits a full step
module fpw_step_timer
   import fpw_pkg::*;
#(
   parameter int T0_CYC = RAMP_T0_CYC,
   parameter int T1_CYC = RAMP_T1_CYC,
   parameter int T2_CYC = RAMP_T2_CYC,
   parameter int T3_CYC = RAMP_T3_CYC
) (
   // clock and reset
   input wire logic  CLK,
   input wire logic  ARST_N,
   // step link
   fpw_step_if.timer st
);
   logic [STEP_CNT_W-1:0] cnt;
   logic [STEP_CNT_W-1:0] last;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      unique case (st.code)
         2'b00: last = STEP_CNT_W'(T0_CYC - 1);
         2'b01: last = STEP_CNT_W'(T1_CYC - 1);
         2'b10: last = STEP_CNT_W'(T2_CYC - 1);
         2'b11: last = STEP_CNT_W'(T3_CYC - 1);
      endcase
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         cnt     <= '0;
         st.tick <= 1'b0;
      end else if (!st.run) begin
         cnt     <= '0;
         st.tick <= 1'b0;
      end else if (cnt >= last) begin
         cnt     <= '0;
         st.tick <= 1'b1;
      end else begin
         cnt     <= cnt + 1'b1;
         st.tick <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   tick_space_a: assert property (@(posedge CLK) disable iff (!ARST_N)
      st.tick |=> !st.tick) else $error("step tick lasted more than one cycle");
endmodule : fpw_step_timer

// ==== src/fpw_duty_cfg.sv ====
// Purpose: enhanced fan duty configuration, smoothing and setpoint format
// Assumes: register strobes and fan-logic inputs synchronous to CLK
// Notes:   read data follows REG_ADDR by one cycle
//
// What this block does
// - fine duty resolution only takes effect at the 22.5 kHz output frequency
// - duty steps 6.25 % when fine bit clear, 0.39 % when set
// - setpoint format bit clear: high and critical setpoints read as signed
// - setpoint format bit set: high and critical setpoints read as unsigned
// - interval code picks 0.023, 0.046, 0.091 or 0.182 s per ramp step
// - interval code writable only while duty programming is enabled
// - smoothing enable writable only while duty programming is enabled
// - smoothing off: duty changes at once; on: ramps at chosen interval
// - spin-up and critical event bypass smoothing and apply duty at once
// - only lookup-table transitions are smoothed
// - smoothing only works at 22.5 kHz; otherwise no ramping
// - top two bits of fan config register always read zero
// - programming on: duty value writable; off: duty follows lookup table
module fpw_duty_cfg
   import fpw_pkg::*;
#(
   parameter int RAMP_T0 = RAMP_T0_CYC,
   parameter int RAMP_T1 = RAMP_T1_CYC,
   parameter int RAMP_T2 = RAMP_T2_CYC,
   parameter int RAMP_T3 = RAMP_T3_CYC
) (
   // clock and reset
   input  wire logic        CLK,
   input  wire logic        ARST_N,
   // register port
   input  wire logic [7:0]  REG_ADDR,
   input  wire logic [7:0]  REG_WDATA,
   input  wire logic        REG_WR,
   output logic      [7:0]  REG_RD_DATA,
   // fan control context
   input  wire logic        FREQ_22K5,
   input  wire logic [7:0]  LUT_DUTY,
   input  wire logic        SPINUP_ACTIVE,
   input  wire logic [7:0]  SPINUP_DUTY,
   input  wire logic        CRIT_EVENT,
   // temperature compare
   input  wire logic [10:0] TEMP_REMOTE,
   input  wire logic [10:0] HIGH_SETPOINT,
   input  wire logic [7:0]  CRIT_SETPOINT,
   // results
   output logic      [7:0]  DUTY,
   output logic             FINE_ACTIVE,
   output logic             HIGH_OVER,
   output logic             CRIT_OVER
);
   logic [7:0]  enh_cfg;
   logic [7:0]  fan_cfg;
   logic [7:0]  pwm_value;
   logic        prog_en;
   logic        fine_eff;
   logic        smooth_eff;
   logic [7:0]  step;
   logic [7:0]  target;
   logic        ramping;
   logic [7:0]  next_duty;
   logic [11:0] temp_ext;
   logic [11:0] high_ext;
   logic [8:0]  critical_temp_event_ext;
   logic [8:0]  crit_ext;
   fpw_src_e    src;
   fpw_step_if  st ();

   assign prog_en    = fan_cfg[FAN_PROG];
   assign fine_eff   = enh_cfg[ENH_FINE] & FREQ_22K5;
   assign smooth_eff = enh_cfg[ENH_SMOOTH] & FREQ_22K5;
   assign step       = fine_eff ? STEP_FINE : STEP_COARSE;

   ////////////////////////////////////////////////////////////////////////////
   // register writes
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         enh_cfg <= ENH_RST;
      end else if (REG_WR && REG_ADDR == ADDR_ENH_CFG) begin
         // bit 7 stays zero; smoothing fields locked unless programming is on
         if (prog_en) begin
            enh_cfg <= REG_WDATA & (ENH_FREE_MASK | ENH_PROT_MASK);
         end else begin
            enh_cfg <= (REG_WDATA & ENH_FREE_MASK) | (enh_cfg & ENH_PROT_MASK);
         end
      end
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         fan_cfg <= FAN_RST;
      end else if (REG_WR && REG_ADDR == ADDR_FAN_CFG) begin
         fan_cfg <= REG_WDATA & FAN_RD_MASK;
      end
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         pwm_value <= PWM_RST;
      end else if (REG_WR && REG_ADDR == ADDR_PWM_VAL && prog_en) begin
         pwm_value <= REG_WDATA;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register reads; the duty register shows the live output
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         REG_RD_DATA <= 8'h00;
      end else begin
         unique case (REG_ADDR)
            ADDR_ENH_CFG: REG_RD_DATA <= enh_cfg;
            ADDR_FAN_CFG: REG_RD_DATA <= fan_cfg & FAN_RD_MASK;
            ADDR_PWM_VAL: REG_RD_DATA <= DUTY;
            default:      REG_RD_DATA <= 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // duty source; critical override beats spin-up beats programmed value
   always_comb begin
      if (CRIT_EVENT) begin
         src = SRC_CRIT;
      end else if (SPINUP_ACTIVE) begin
         src = SRC_SPIN;
      end else if (prog_en) begin
         src = SRC_SOFT;
      end else begin
         src = SRC_LUT;
      end
   end

   always_comb begin
      unique case (src)
         SRC_CRIT: target = fpw_quant(DUTY_FULL, fine_eff);
         SRC_SPIN: target = fpw_quant(SPINUP_DUTY, fine_eff);
         SRC_SOFT: target = fpw_quant(pwm_value, fine_eff);
         SRC_LUT:  target = fpw_quant(LUT_DUTY, fine_eff);
         default:  target = fpw_quant(DUTY_FULL, fine_eff);
      endcase
   end

   // only lookup-table moves ramp; a stale off-grid duty snaps first
   assign ramping = (src == SRC_LUT) && smooth_eff
                    && (DUTY != target) && (fpw_quant(DUTY, fine_eff) == DUTY);

   ////////////////////////////////////////////////////////////////////////////
   // ramp pacing
   assign st.run  = ramping;
   assign st.code = enh_cfg[ENH_RATE_HI:ENH_RATE_LO];

   fpw_step_timer #(
      .T0_CYC (RAMP_T0),
      .T1_CYC (RAMP_T1),
      .T2_CYC (RAMP_T2),
      .T3_CYC (RAMP_T3)
   ) u_step (
      .CLK    (CLK),
      .ARST_N (ARST_N),
      .st     (st.timer)
   );

   always_comb begin
      next_duty = DUTY;
      if (!ramping) begin
         next_duty = target;
      end else if (st.tick) begin
         if (DUTY < target) begin
            next_duty = DUTY + step;
         end else begin
            next_duty = DUTY - step;
         end
      end
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         DUTY        <= 8'h00;
         FINE_ACTIVE <= 1'b0;
      end else begin
         DUTY        <= next_duty;
         FINE_ACTIVE <= fine_eff;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // setpoint compare; the remote reading itself is always unsigned
   assign temp_ext  = {1'b0, TEMP_REMOTE};
   assign critical_temp_event_ext = {1'b0, TEMP_REMOTE[10:3]};
   assign high_ext  = enh_cfg[ENH_USF] ? {1'b0, HIGH_SETPOINT}
                                       : {HIGH_SETPOINT[10], HIGH_SETPOINT};
   assign crit_ext  = enh_cfg[ENH_USF] ? {1'b0, CRIT_SETPOINT}
                                       : {CRIT_SETPOINT[7], CRIT_SETPOINT};

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         HIGH_OVER <= 1'b0;
         CRIT_OVER <= 1'b0;
      end else begin
         HIGH_OVER <= $signed(temp_ext) > $signed(high_ext);
         CRIT_OVER <= $signed(critical_temp_event_ext) > $signed(crit_ext);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   rate_lock_a: assert property (@(posedge CLK) disable iff (!ARST_N)
      REG_WR && REG_ADDR == ADDR_ENH_CFG && !prog_en
      |=> enh_cfg[ENH_RATE_HI:ENH_RATE_LO] == $past(enh_cfg[ENH_RATE_HI:ENH_RATE_LO]))
      else $error("interval code changed while programming disabled");

   smooth_lock_a: assert property (@(posedge CLK) disable iff (!ARST_N)
      REG_WR && REG_ADDR == ADDR_ENH_CFG && !prog_en
      |=> enh_cfg[ENH_SMOOTH] == $past(enh_cfg[ENH_SMOOTH]))
      else $error("smoothing enable changed while programming disabled");

   rsvd_read_a: assert property (@(posedge CLK) disable iff (!ARST_N)
      REG_ADDR == ADDR_FAN_CFG |=> REG_RD_DATA[7:6] == 2'b00)
      else $error("fan config upper bits read nonzero");

   crit_now_a: assert property (@(posedge CLK) disable iff (!ARST_N)
      CRIT_EVENT |=> DUTY == fpw_quant(DUTY_FULL, $past(fine_eff)))
      else $error("critical override not applied at once");

   spin_now_a: assert property (@(posedge CLK) disable iff (!ARST_N)
      SPINUP_ACTIVE && !CRIT_EVENT |=> DUTY == $past(target))
      else $error("spin-up duty was smoothed");

   no_smooth_a: assert property (@(posedge CLK) disable iff (!ARST_N)
      !enh_cfg[ENH_SMOOTH] |=> DUTY == $past(target))
      else $error("duty ramped with smoothing disabled");

   slow_freq_a: assert property (@(posedge CLK) disable iff (!ARST_N)
      !FREQ_22K5 |=> DUTY == $past(target) && DUTY[3:0] == 4'h0)
      else $error("ramp or fine duty outside 22.5 kHz");

   coarse_grid_a: assert property (@(posedge CLK) disable iff (!ARST_N)
      !fine_eff && !ramping |=> DUTY[3:0] == 4'h0)
      else $error("coarse duty off the 6.25 percent grid");

   prog_src_a: assert property (@(posedge CLK) disable iff (!ARST_N)
      prog_en && !SPINUP_ACTIVE && !CRIT_EVENT
      |=> DUTY == fpw_quant($past(pwm_value), $past(fine_eff)))
      else $error("duty did not follow programmed value");

   ramp_step_a: assert property (@(posedge CLK) disable iff (!ARST_N)
      ramping && st.tick && DUTY < target |=> DUTY == $past(DUTY) + $past(step))
      else $error("ramp step size wrong");

   ramp_hold_a: assert property (@(posedge CLK) disable iff (!ARST_N)
      ramping && !st.tick |=> $stable(DUTY))
      else $error("duty moved between ramp steps");

   signed_sp_a: assert property (@(posedge CLK) disable iff (!ARST_N)
      !enh_cfg[ENH_USF] && HIGH_SETPOINT[10] |=> HIGH_OVER)
      else $error("negative signed setpoint not exceeded");

   unsigned_sp_a: assert property (@(posedge CLK) disable iff (!ARST_N)
      enh_cfg[ENH_USF] && HIGH_SETPOINT[10] && !TEMP_REMOTE[10] |=> !HIGH_OVER)
      else $error("unsigned setpoint treated as negative");
endmodule : fpw_duty_cfg

// ==== testbench/fpw_fan_model.sv ====
// Purpose: four-pin fan standing on the duty output
// Assumes: duty sampled on clk, 1/256 full scale per lsb
// Notes:   speed trails duty by one lsb per cycle, a crude stand-in for rotor inertia
module fpw_fan_model (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       arst_n,
   // drive and response
   input  wire logic [7:0] duty,
   output logic      [7:0] speed
);
   timeunit 1ns;
   timeprecision 1ns;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         speed <= 8'h00;
      end else if (speed < duty) begin
         speed <= speed + 8'h01;
      end else if (speed > duty) begin
         speed <= speed - 8'h01;
      end
   end
endmodule : fpw_fan_model

// ==== testbench/fan_pwm_enhanced_config_tb_top.sv ====
// Purpose: self-checking bench for the fan duty configuration block
// Assumes: ramp intervals shortened to 4, 8, 16 and 32 cycles
// Notes:   inputs move 1 ns after the rising edge
module fan_pwm_enhanced_config_tb_top
   import fpw_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} fpw_row_s;
   logic        CLK, ARST_N, REG_WR, FREQ_22K5, SPINUP_ACTIVE, CRIT_EVENT;
   logic [7:0]  REG_ADDR, REG_WDATA, REG_RD_DATA, LUT_DUTY, SPINUP_DUTY, CRIT_SETPOINT;
   logic [10:0] TEMP_REMOTE, HIGH_SETPOINT;
   logic [7:0]  DUTY, fan_speed;
   logic        FINE_ACTIVE, HIGH_OVER, CRIT_OVER;
   int          errors, n_compared, k;
   int          ivl[4] = '{4, 8, 16, 32};
   fpw_row_s    rows[7] = '{'{8'h45, 8'hFF, 8'h7F}, '{8'h4A, 8'hFF, 8'h3F},
      '{8'h4A, 8'h00, 8'h00}, '{8'h45, 8'h00, 8'h07}, '{8'h30, 8'hAA, 8'h00},
      '{8'h4A, 8'h20, 8'h20}, '{8'h45, 8'h00, 8'h00}};
   ////////////////////////////////////////////////////////////////////////////
   fpw_duty_cfg #(.RAMP_T0(4), .RAMP_T1(8), .RAMP_T2(16), .RAMP_T3(32)) dut (
      .CLK(CLK), .ARST_N(ARST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
      .REG_WR(REG_WR), .REG_RD_DATA(REG_RD_DATA), .FREQ_22K5(FREQ_22K5),
      .LUT_DUTY(LUT_DUTY), .SPINUP_ACTIVE(SPINUP_ACTIVE), .SPINUP_DUTY(SPINUP_DUTY),
      .CRIT_EVENT(CRIT_EVENT), .TEMP_REMOTE(TEMP_REMOTE), .HIGH_SETPOINT(HIGH_SETPOINT),
      .CRIT_SETPOINT(CRIT_SETPOINT), .DUTY(DUTY), .FINE_ACTIVE(FINE_ACTIVE),
      .HIGH_OVER(HIGH_OVER), .CRIT_OVER(CRIT_OVER));
   fpw_fan_model fan (.clk(CLK), .arst_n(ARST_N), .duty(DUTY), .speed(fan_speed));
   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic cyc(input int n);
      repeat (n) @(posedge CLK);
      #1;
   endtask : cyc
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      cyc(1);
      REG_ADDR  = a;
      REG_WDATA = d;
      REG_WR    = 1'b1;
      cyc(1);
      REG_WR    = 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      cyc(1);
      REG_ADDR = a;
      cyc(2);
      check("read data", REG_RD_DATA, exp);
   endtask : rd
   task automatic close_out();
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : close_out
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      CLK = 1'b0;
      forever #50 CLK = ~CLK;
   end
   initial begin
      repeat (20000) @(posedge CLK);
      errors++;
      close_out();
   end
   initial begin
      ARST_N = 1'b0;
      REG_ADDR = 8'h00;
      REG_WDATA = 8'h00;
      REG_WR = 1'b0;
      FREQ_22K5 = 1'b1;
      LUT_DUTY = 8'h00;
      SPINUP_ACTIVE = 1'b0;
      SPINUP_DUTY = 8'h00;
      CRIT_EVENT = 1'b0;
      TEMP_REMOTE = 11'h010;
      HIGH_SETPOINT = 11'h7FF;
      CRIT_SETPOINT = 8'h80;
      cyc(4);
      ARST_N = 1'b1;
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         rd(rows[i].a, rows[i].e);
      end
      $display("test register rows done");
      wr(8'h4C, 8'h37);
      cyc(2);
      check("coarse duty", DUTY, 8'h30);
      rd(8'h4C, 8'h30);
      wr(8'h45, 8'h10);
      cyc(2);
      check("fine duty", DUTY, 8'h37);
      check("fine active", {7'h00, FINE_ACTIVE}, 8'h01);
      FREQ_22K5 = 1'b0;
      cyc(2);
      check("fine off freq", DUTY, 8'h30);
      check("fine inactive", {7'h00, FINE_ACTIVE}, 8'h00);
      FREQ_22K5 = 1'b1;
      wr(8'h4A, 8'h00);
      wr(8'h4C, 8'h55);
      cyc(2);
      check("lut duty", DUTY, 8'h00);
      // the refused write must leave the programmed value as it was
      wr(8'h4A, 8'h20);
      cyc(2);
      check("locked pwm value", DUTY, 8'h37);
      $display("test resolution done");
      for (int c = 0; c < 4; c++) begin
         wr(8'h4A, 8'h20);
         wr(8'h45, 8'h11 | {5'h00, c[1:0], 1'b0});
         wr(8'h4C, 8'h00);
         LUT_DUTY = 8'h00;
         wr(8'h4A, 8'h00);
         cyc(3);
         LUT_DUTY = 8'h02;
         cyc(2);
         check("ramp hold", DUTY, 8'h00);
         k = 0;
         while (DUTY === 8'h00 && k < 100) begin
            cyc(1);
            k++;
         end
         check("ramp first", DUTY, 8'h01);
         k = 0;
         while (DUTY === 8'h01 && k < 100) begin
            cyc(1);
            k++;
         end
         check("ramp second", DUTY, 8'h02);
         check("ramp interval", k[7:0], ivl[c][7:0]);
      end
      $display("test ramp done");
      CRIT_EVENT = 1'b1;
      cyc(2);
      check("crit duty", DUTY, 8'hFF);
      CRIT_EVENT = 1'b0;
      SPINUP_ACTIVE = 1'b1;
      SPINUP_DUTY = 8'h80;
      cyc(2);
      check("spin duty", DUTY, 8'h80);
      SPINUP_ACTIVE = 1'b0;
      FREQ_22K5 = 1'b0;
      LUT_DUTY = 8'h20;
      cyc(2);
      check("no ramp slow freq", DUTY, 8'h20);
      // long enough for the fan to settle from any earlier speed
      cyc(260);
      check("slow freq hold", DUTY, 8'h20);
      check("fan speed", fan_speed, 8'h20);
      $display("test bypass done");
      for (int u = 0; u < 2; u++) begin
         wr(8'h45, {4'h0, u[0], 3'h0});
         cyc(2);
         check("high over", {7'h00, HIGH_OVER}, {7'h00, ~u[0]});
         check("crit over", {7'h00, CRIT_OVER}, {7'h00, ~u[0]});
      end
      $display("test setpoint format done");
      // coarse ramp; the interval code must still be 11 after the locked writes
      FREQ_22K5 = 1'b1;
      LUT_DUTY = 8'h40;
      cyc(2);
      check("coarse ramp hold", DUTY, 8'h20);
      k = 0;
      while (DUTY === 8'h20 && k < 100) begin
         cyc(1);
         k++;
      end
      check("coarse ramp first", DUTY, 8'h30);
      k = 0;
      while (DUTY === 8'h30 && k < 100) begin
         cyc(1);
         k++;
      end
      check("coarse ramp second", DUTY, 8'h40);
      check("locked interval", k[7:0], ivl[3][7:0]);
      $display("test coarse ramp done");
      ARST_N = 1'b0;
      cyc(2);
      check("duty in reset", DUTY, 8'h00);
      ARST_N = 1'b1;
      rd(8'h45, 8'h00);
      rd(8'h4A, 8'h20);
      $display("test reset done");
      close_out();
   end
endmodule : fan_pwm_enhanced_config_tb_top
